/* verilog/flash_crc_scan_control.sv */
// flash crc scanner: apb registers, scan sequencer and nmi
`timescale 1ns/1ps
// Behaviour
// - writing pass flag zero raises nmi when nmi trigger enable is set
// - after nmi is raised every register write is ignored until reset
// - writing pass flag one makes it read one when not busy
// - debugger writes to control registers act like processor writes
// - strobe bit 7 clears enable, select and status one cycle later
// - with nmi enable zero strobe reset is accepted even while busy
// - with nmi enable one strobe reset is accepted only when idle
// - nmi enable bit 1 makes any checksum failure raise nmi
// - nmi enable cleared only by system reset, not by strobe reset
// - nmi enable may be written one only while not busy
// - enable bit 0 written one starts check; stays one after
// - enable written zero stops only after current section ends
// - after a startup scan enable reads one when code starts
// - section select writes ignored while busy or after nmi
// - select 0 whole flash, 1 loader plus app, 2 loader, 3 reserved
// - after startup scan select reads the region that was checked
// - status resets to 0x02 and is read-only to ordinary software
// - pass flag one from reset, cleared on enable, set on pass
// - busy bit 0 reads one while check runs; writes restricted
// - crc-16-ccitt, bytes from zero, msb first, initial 0xffff
// - first fetch four cycles after the enable write, after three wait cycles
// - one flash word fetched every third cycle, stalling the cpu
// - mismatch clears pass flag; nmi request held until reset
module flash_crc_scan_control #(
  parameter int AW = crc_scan_pkg::FLASH_WORD_AW  // flash word address
) (
  input  wire logic                   clk_sys,       // system clock
  input  wire logic                   rstn,          // sync reset, low
  input  wire crc_scan_pkg::apbReq_s  apbReq,        // apb request
  output crc_scan_pkg::apbRsp_s       apbRsp,        // apb answer
  input  wire logic                   dbgAccess,     // write from debugger
  output crc_scan_pkg::flashReq_s     flashReq,      // word fetch
  input  wire logic [15:0]            flashRdata,    // word, 1 cycle late
  input  wire logic [AW-1:0]          loaderEndWord, // last loader word
  input  wire logic [AW-1:0]          appEndWord,    // last app word
  input  wire logic [AW-1:0]          flashEndWord,  // last flash word
  input  wire logic                   bootScanEn,    // startup scan strap
  input  wire logic [1:0]             bootScanSrc,   // startup region
  output logic                        cpuStall,      // scanner owns flash
  output logic                        cpuRelease,    // code may run
  output logic                        nmiReq         // non-maskable irq
);

  // one byte through the ccitt shift register, msb first
  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0]  b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ b[i]) begin
        r = {r[14:0], 1'b0} ^ crc_scan_pkg::CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction : crcByte

  function automatic logic [crc_scan_pkg::APB_AW-1:0] regAddr(
    input logic [7:0] idx);
    return crc_scan_pkg::APB_AW'({idx, 2'b00});
  endfunction : regAddr

  // one flag placed at its field position in a register byte
  function automatic logic [7:0] flagAt(input logic f,
                                        input int   pos);
    logic [7:0] r;
    r = 8'h00;
    r[pos[2:0]] = f;
    return r;
  endfunction : flagAt

  // registers
  logic                       enable_q;
  logic                       nmi_trigger_enable_q;
  logic [1:0]                 src_q;
  logic                       busy_q;
  logic                       pass_q;
  logic                       nmi_q;
  logic                       strobePend_q;
  crc_scan_pkg::scan_e        state_q;
  logic [1:0]                 count_q;
  logic [AW-1:0]              addr_q;
  logic [15:0]                crc_q;
  logic [31:0]                rdata_q;
  logic                       startSeen_q;
  logic                       bootCheck_q;
  logic                       release_q;

  // apb decode
  wire setupPh  = apbReq.psel & ~apbReq.penable;
  wire accessPh = apbReq.psel & apbReq.penable;
  wire hitA     = apbReq.paddr == regAddr(crc_scan_pkg::REG_IDX_CTRL_A);
  wire hitB     = apbReq.paddr == regAddr(crc_scan_pkg::REG_IDX_CTRL_B);
  wire hitS     = apbReq.paddr == regAddr(crc_scan_pkg::REG_IDX_STATE);
  wire mapped   = hitA | hitB | hitS;
  // a raised nmi locks the whole register file
  wire wrOk     = accessPh & apbReq.pwrite & mapped & ~nmi_q;
  // processor and debugger share the control write path
  wire wrA      = wrOk & hitA;
  wire wrB      = wrOk & hitB;
  // status is writable by the debugger only
  wire wrS      = wrOk & hitS & dbgAccess;
  wire [7:0] wd = apbReq.pwdata[7:0];

  wire strobeReq = wrA & wd[crc_scan_pkg::CTRL_STROBE_BIT] &
                   (~nmi_trigger_enable_q | ~busy_q);
  wire enWr1     = wrA & wd[crc_scan_pkg::CTRL_ENABLE_BIT];
  // restricted while busy
  wire nmiEnSet  = wrA & wd[crc_scan_pkg::CTRL_NMI_TRIGGER_ENABLE_BIT] & ~busy_q;
  wire srcWr     = wrB & ~busy_q;
  wire dbgPass0  = wrS & ~wd[crc_scan_pkg::STATE_PASS_BIT];
  wire dbgPass1  = wrS & wd[crc_scan_pkg::STATE_PASS_BIT];
  wire dbgBusy0  = wrS & ~wd[crc_scan_pkg::STATE_BUSY_BIT];
  wire dbgBusy1  = wrS & wd[crc_scan_pkg::STATE_BUSY_BIT];

  // startup scan straps are caught in the first cycle after reset
  wire bootKick  = ~startSeen_q & bootScanEn;
  wire [1:0] runSrc = bootKick ? bootScanSrc : src_q;
  wire srcLegal  = runSrc != crc_scan_pkg::SRC_RESERVED;
  wire startReq  = (bootKick | enWr1 | dbgBusy1) & srcLegal &
                   ~strobeReq & ~strobePend_q;

  // section end per select code
  wire [AW-1:0] lastWord =
    (src_q == crc_scan_pkg::SRC_LOADER)     ? loaderEndWord :
    (src_q == crc_scan_pkg::SRC_LOADER_APP) ? appEndWord    :
                                              flashEndWord;

  // byte 0 is the low byte of a word, bytes go msb first
  wire [15:0] crcLow  = crcByte(crc_q, flashRdata[7:0]);
  wire [15:0] crcWord = crcByte(crcLow, flashRdata[15:8]);

  wire running   = state_q == crc_scan_pkg::SCAN_RUN;
  wire dataPh    = running & (count_q == crc_scan_pkg::PHASE_DATA);
  wire lastData  = dataPh & (addr_q == lastWord);
  // stored checksum folded in leaves a zero residue
  wire scanPass  = crcWord == crc_scan_pkg::CRC_RESIDUE;
  wire scanFail  = lastData & ~scanPass;
  wire abortScan = strobePend_q | dbgBusy0;
  wire failEvent = (scanFail & ~abortScan) | dbgPass0;

  // sequencer: wait three cycles, then fetch every third cycle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= crc_scan_pkg::SCAN_IDLE;
      count_q <= 2'h0;
    end else if (abortScan) begin
      state_q <= crc_scan_pkg::SCAN_IDLE;
      count_q <= 2'h0;
    end else if (startReq) begin
      state_q <= crc_scan_pkg::SCAN_WAIT;
      count_q <= 2'h1;
    end else begin
      unique case (state_q)
        crc_scan_pkg::SCAN_IDLE: begin
          count_q <= 2'h0;
        end
        crc_scan_pkg::SCAN_WAIT: begin
          if (count_q == crc_scan_pkg::START_DELAY) begin
            state_q <= crc_scan_pkg::SCAN_RUN;
            count_q <= crc_scan_pkg::PHASE_FETCH;
          end else begin
            count_q <= count_q + 2'h1;
          end
        end
        crc_scan_pkg::SCAN_RUN: begin
          // clearing enable does not cut the section short
          if (lastData) begin
            state_q <= crc_scan_pkg::SCAN_IDLE;
            count_q <= 2'h0;
          end else if (count_q == crc_scan_pkg::FETCH_PERIOD - 2'h1) begin
            count_q <= crc_scan_pkg::PHASE_FETCH;
          end else begin
            count_q <= count_q + 2'h1;
          end
        end
      endcase
    end
  end

  // word address and running crc
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      addr_q <= '0;
      crc_q  <= crc_scan_pkg::CRC_INIT;
    end else if (startReq) begin
      addr_q <= '0;
      crc_q  <= crc_scan_pkg::CRC_INIT;
    end else if (dataPh) begin
      addr_q <= addr_q + AW'(1);
      crc_q  <= crcWord;
    end
  end

  // strobe reset takes hold one cycle after the write
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      strobePend_q <= 1'b0;
    end else begin
      strobePend_q <= strobeReq;
    end
  end

  // control a: enable and nmi trigger enable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      enable_q <= crc_scan_pkg::CTRL_A_RESET[crc_scan_pkg::CTRL_ENABLE_BIT];
      nmi_trigger_enable_q  <= crc_scan_pkg::CTRL_A_RESET[crc_scan_pkg::CTRL_NMI_TRIGGER_ENABLE_BIT];
    end else begin
      if (strobePend_q) begin
        enable_q <= 1'b0;
      end else if (bootKick) begin
        enable_q <= 1'b1;
      end else if (wrA) begin
        enable_q <= wd[crc_scan_pkg::CTRL_ENABLE_BIT];
      end
      // strobe reset leaves the trigger enable alone
      if (nmiEnSet) begin
        nmi_trigger_enable_q <= 1'b1;
      end
    end
  end

  // control b: section select
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      src_q <= crc_scan_pkg::CTRL_B_RESET[1:0];
    end else if (strobePend_q) begin
      src_q <= crc_scan_pkg::STROBE_CLEAR[1:0];
    end else if (bootKick) begin
      src_q <= bootScanSrc;
    end else if (srcWr) begin
      src_q <= wd[1:0];
    end
  end

  // status: busy and pass
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy_q <= crc_scan_pkg::STATE_RESET[crc_scan_pkg::STATE_BUSY_BIT];
      pass_q <= crc_scan_pkg::STATE_RESET[crc_scan_pkg::STATE_PASS_BIT];
    end else if (strobePend_q) begin
      busy_q <= crc_scan_pkg::STROBE_CLEAR[crc_scan_pkg::STATE_BUSY_BIT];
      pass_q <= crc_scan_pkg::STROBE_CLEAR[crc_scan_pkg::STATE_PASS_BIT];
    end else if (startReq) begin
      busy_q <= 1'b1;
      pass_q <= 1'b0;
    end else if (dbgBusy0) begin
      busy_q <= 1'b0;
      pass_q <= dbgPass1 | (pass_q & ~dbgPass0);
    end else if (lastData) begin
      busy_q <= 1'b0;
      pass_q <= scanPass;
    end else if (dbgPass0) begin
      pass_q <= 1'b0;
    end else if (dbgPass1 & ~busy_q) begin
      pass_q <= 1'b1;
    end
  end

  // nmi request is sticky until system reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      nmi_q <= 1'b0;
    end else if (failEvent & nmi_trigger_enable_q) begin
      nmi_q <= 1'b1;
    end
  end

  // startup scan gates the first instruction
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      startSeen_q <= 1'b0;
      bootCheck_q <= 1'b0;
      release_q   <= 1'b0;
    end else begin
      startSeen_q <= 1'b1;
      if (!startSeen_q) begin
        bootCheck_q <= bootScanEn & srcLegal;
        release_q   <= ~(bootScanEn & srcLegal);
      end else if (bootCheck_q & lastData) begin
        // a failed startup check leaves the cpu parked for good
        bootCheck_q <= 1'b0;
        release_q   <= scanPass;
      end
    end
  end

  // read data captured in setup so it comes from a flip-flop
  wire [7:0] ctrlAView = flagAt(enable_q, crc_scan_pkg::CTRL_ENABLE_BIT) |
                         flagAt(nmi_trigger_enable_q, crc_scan_pkg::CTRL_NMI_TRIGGER_ENABLE_BIT);
  wire [7:0] ctrlBView = {6'h00, src_q};
  wire [7:0] stateView = flagAt(busy_q, crc_scan_pkg::STATE_BUSY_BIT) |
                         flagAt(pass_q, crc_scan_pkg::STATE_PASS_BIT);
  wire [7:0] readByte  = hitA ? ctrlAView :
                         hitB ? ctrlBView :
                         hitS ? stateView : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (setupPh & ~apbReq.pwrite) begin
      rdata_q <= {24'h00_0000, readByte};
    end
  end

  assign apbRsp.prdata  = rdata_q;
  assign apbRsp.pready  = 1'b1;
  // unmapped addresses answer with an error, writes are dropped
  assign apbRsp.pslverr = accessPh & ~mapped;

  // flash fetch pulse in phase zero of each three-cycle slot
  assign flashReq.rd   = running & (count_q == crc_scan_pkg::PHASE_FETCH);
  assign flashReq.addr = addr_q;
  assign cpuStall      = running;
  assign cpuRelease    = release_q;
  assign nmiReq        = nmi_q;

endmodule : flash_crc_scan_control

/* common/crc_scan_pkg.sv */
// shared constants and carrier types of the flash crc scanner
package crc_scan_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] REG_IDX_CTRL_A = 8'h00;
  localparam logic [7:0] REG_IDX_CTRL_B = 8'h01;
  localparam logic [7:0] REG_IDX_STATE  = 8'h02;
  localparam int         APB_AW         = 12;
  localparam int         FLASH_WORD_AW  = 15;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_NMI_TRIGGER_ENABLE_BIT  = 1;
  localparam int CTRL_STROBE_BIT = 7;
  localparam int STATE_BUSY_BIT  = 0;
  localparam int STATE_PASS_BIT  = 1;

  // reset values
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] STATE_RESET  = 8'h02;
  localparam logic [7:0] STROBE_CLEAR = 8'h00;

  // section select codes
  localparam logic [1:0] SRC_WHOLE_FLASH = 2'h0;
  localparam logic [1:0] SRC_LOADER_APP  = 2'h1;
  localparam logic [1:0] SRC_LOADER      = 2'h2;
  localparam logic [1:0] SRC_RESERVED    = 2'h3;

  // crc-16-ccitt
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // timing in clk_sys cycles
  localparam logic [1:0] START_DELAY  = 2'h3;
  localparam logic [1:0] FETCH_PERIOD = 2'h3;
  localparam logic [1:0] PHASE_FETCH  = 2'h0;
  localparam logic [1:0] PHASE_DATA   = 2'h1;

  typedef enum logic [1:0] {SCAN_IDLE, SCAN_WAIT, SCAN_RUN} scan_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } apbReq_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apbRsp_s;

  typedef struct packed {
    logic                     rd;
    logic [FLASH_WORD_AW-1:0] addr;
  } flashReq_s;
endpackage : crc_scan_pkg

/* test/flash_model.sv */
// behavioural program flash answering the scanner's word fetches
`timescale 1ns/1ps
module flash_model (
  input  wire logic                    clk_sys,    // system clock
  input  wire crc_scan_pkg::flashReq_s flashReq,   // word fetch
  output logic [15:0]                  flashRdata  // word, one cycle late
);
  logic [15:0] mem [0:63];
  initial flashRdata = 16'h5a5a;
  // outside the data cycle the bus toggles so stale words never match
  always @(posedge clk_sys) begin
    if (flashReq.rd === 1'b1)
      flashRdata <= mem[flashReq.addr[5:0]];
    else
      flashRdata <= ~flashRdata;
  end
endmodule : flash_model

/* test/crc_scan_chk_sva.sv */
// port assertions for the flash crc scanner
`timescale 1ns/1ps
module crc_scan_chk (
  input wire logic                    clk_sys,    // clock
  input wire logic                    rstn,       // reset, low
  input wire crc_scan_pkg::apbReq_s   apbReq,     // apb request
  input wire crc_scan_pkg::apbRsp_s   apbRsp,     // apb answer
  input wire crc_scan_pkg::flashReq_s flashReq,   // fetch
  input wire logic                    cpuStall,   // stall
  input wire logic                    cpuRelease, // code may run
  input wire logic                    nmiReq      // nmi
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic acc;
  logic wrA;
  logic mapped;
  assign acc = apbReq.psel && apbReq.penable;
  assign wrA = acc && apbReq.pwrite && apbReq.paddr == 12'h000;
  assign mapped = apbReq.paddr inside {12'h000, 12'h004, 12'h008};
  property p_gap;
    flashReq.rd |=> !flashReq.rd ##1 !flashReq.rd;
  endproperty
  a_gap: assert property (p_gap)
    else $error("fetches closer than three cycles");
  property p_step;
    flashReq.rd ##3 flashReq.rd |-> flashReq.addr == '0
      || flashReq.addr == $past(flashReq.addr, 3) + 15'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("fetch address skipped");
  property p_stall;
    flashReq.rd |-> cpuStall;
  endproperty
  a_stall: assert property (p_stall)
    else $error("fetch without cpu stall");
  property p_start;
    wrA && apbReq.pwdata[0] && !apbReq.pwdata[7] && !nmiReq && !cpuStall
      |=> !flashReq.rd [*3];
  endproperty
  a_start: assert property (p_start)
    else $error("scan began too early");
  property p_nmiHold;
    nmiReq |=> nmiReq;
  endproperty
  a_nmiHold: assert property (p_nmiHold)
    else $error("nmi request dropped");
  property p_nmiLock;
    nmiReq && !cpuStall && wrA && apbReq.pwdata[0] |=> !cpuStall [*4];
  endproperty
  a_nmiLock: assert property (p_nmiLock)
    else $error("scan started after nmi");
  property p_rel;
    cpuRelease |=> cpuRelease;
  endproperty
  a_rel: assert property (p_rel)
    else $error("cpu release withdrawn");
  property p_rst;
    disable iff (1'b0) !rstn |=> !nmiReq && !cpuStall && !flashReq.rd;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
  property p_bus;
    apbRsp.pready && apbRsp.pslverr == (acc && !mapped);
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer wrong");
endmodule : crc_scan_chk
bind flash_crc_scan_control crc_scan_chk u_chk (.clk_sys(clk_sys),
  .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp), .flashReq(flashReq),
  .cpuStall(cpuStall), .cpuRelease(cpuRelease), .nmiReq(nmiReq));

/* test/testbench.sv */
// self-checking bench for the flash crc scanner
`timescale 1ns/1ps
module testbench;
  logic                    clk_sys = 0;
  logic                    rstn = 0;
  crc_scan_pkg::apbReq_s   apbReq = '0;
  crc_scan_pkg::apbRsp_s   apbRsp;
  crc_scan_pkg::flashReq_s flashReq;
  logic                    dbgAccess = 0;
  logic [15:0]             flashRdata;
  logic                    bootScanEn = 0;
  logic [1:0]              bootScanSrc = 2'h0;
  logic                    cpuStall;
  logic                    cpuRelease;
  logic                    nmiReq;
  logic [31:0]             q;
  logic [31:0]             seed = 32'ha5c6;
  logic                    err;
  int miscompares = 0, nChecks = 0, nRd = 0, cyc = 0, ea, eb, es, en;
  int firstRd, t0;
  int lastW [3] = '{23, 15, 7};
  flash_crc_scan_control u_dut (.clk_sys(clk_sys), .rstn(rstn),
    .apbReq(apbReq), .apbRsp(apbRsp), .dbgAccess(dbgAccess),
    .flashReq(flashReq), .flashRdata(flashRdata),
    .loaderEndWord(15'h7), .appEndWord(15'hf), .flashEndWord(15'h17),
    .bootScanEn(bootScanEn), .bootScanSrc(bootScanSrc),
    .cpuStall(cpuStall), .cpuRelease(cpuRelease), .nmiReq(nmiReq));
  flash_model u_flash (.clk_sys(clk_sys), .flashReq(flashReq),
    .flashRdata(flashRdata));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (flashReq.rd === 1'b1) begin
      if (nRd == 0)
        firstRd <= cyc;
      nRd <= nRd + 1;
    end
    if (cyc == 30000) begin
      miscompares++;
      finish_test;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  function automatic logic [15:0] crcb(input logic [15:0] c,
                                       input logic [7:0]  b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crcb
  task chk(input logic [31:0] g, input logic [31:0] e);
    nChecks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task xfer(input logic [7:0] i, input logic w, input logic [7:0] d,
            input logic g);
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, w, {2'h0, i, 2'h0}, {24'h0, d}};
    dbgAccess <= g;
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
    q = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    dbgAccess <= 1'b0;
  endtask : xfer
  task regs;
    xfer(8'h00, 0, 0, 0);
    chk(q, ea);
    xfer(8'h01, 0, 0, 0);
    chk(q, eb);
    xfer(8'h02, 0, 0, 0);
    chk(q, es);
    chk({31'h0, nmiReq}, en);
  endtask : regs
  task waitIdle;
    do xfer(8'h02, 0, 0, 0); while (q[0] !== 1'b0);
  endtask : waitIdle
  // last word holds the checksum high byte first, so residue ends at zero
  task prep(input int l, input logic bad);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < l; i++) begin
      seed = xs(seed);
      u_flash.mem[i] = seed[15:0];
      c = crcb(crcb(c, seed[7:0]), seed[15:8]);
    end
    u_flash.mem[l] = {c[7:0], c[15:8]} ^ {15'h0, bad};
  endtask : prep
  task rst(input logic b, input logic [1:0] s);
    rstn <= 1'b0;
    bootScanEn <= b;
    bootScanSrc <= s;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    en = 0;
  endtask : rst
  task finish_test;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    rst(0, 2'h0);
    ea = 0;
    eb = 0;
    es = 2;
    regs;
    xfer(8'h03, 0, 0, 0);
    chk(err, 1);
    xfer(8'h02, 1, 8'h00, 0);
    regs;
    $display("test reset done");
    for (int s = 0; s < 3; s++) begin
      prep(lastW[s], 0);
      xfer(8'h01, 1, 8'(s), 0);
      nRd = 0;
      xfer(8'h00, 1, 8'h01, 0);
      t0 = cyc;
      xfer(8'h02, 0, 0, 0);
      chk(q, 1);
      xfer(8'h01, 1, 8'(s ^ 1), 0);
      ea = 1;
      // enable written low mid-scan must still let the section finish
      if (s == 2) begin
        xfer(8'h00, 1, 8'h02, 0);
        ea = 0;
      end
      waitIdle;
      eb = s;
      regs;
      chk(nRd, lastW[s] + 1);
      chk(firstRd - t0, crc_scan_pkg::START_DELAY + 1);
    end
    $display("test scan done");
    xfer(8'h01, 1, 8'h03, 0);
    nRd = 0;
    xfer(8'h00, 1, 8'h01, 0);
    repeat (20) @(posedge clk_sys);
    ea = 1;
    eb = 3;
    regs;
    chk(nRd, 0);
    xfer(8'h01, 1, 8'h00, 0);
    prep(23, 0);
    xfer(8'h00, 1, 8'h01, 0);
    xfer(8'h00, 1, 8'h80, 0);
    ea = 0;
    eb = 0;
    es = 0;
    regs;
    chk(cpuStall, 0);
    xfer(8'h02, 1, 8'h02, 1);
    xfer(8'h01, 1, 8'h02, 1);
    es = 2;
    eb = 2;
    regs;
    // debugger writing busy one runs a single check of the selected region
    prep(7, 0);
    nRd = 0;
    xfer(8'h02, 1, 8'h01, 1);
    waitIdle;
    regs;
    chk(nRd, lastW[2] + 1);
    $display("test strobe done");
    xfer(8'h00, 1, 8'h02, 0);
    prep(7, 0);
    xfer(8'h00, 1, 8'h03, 0);
    xfer(8'h00, 1, 8'h80, 0);
    xfer(8'h02, 0, 0, 0);
    chk(q, 1);
    waitIdle;
    xfer(8'h00, 1, 8'h80, 0);
    ea = 2;
    eb = 0;
    es = 0;
    regs;
    xfer(8'h01, 1, 8'h02, 0);
    prep(7, 1);
    xfer(8'h00, 1, 8'h03, 0);
    waitIdle;
    xfer(8'h01, 1, 8'h01, 0);
    xfer(8'h00, 1, 8'h81, 0);
    ea = 3;
    eb = 2;
    en = 1;
    regs;
    $display("test nmi done");
    rst(0, 2'h0);
    xfer(8'h00, 1, 8'h02, 0);
    xfer(8'h02, 1, 8'h00, 1);
    ea = 2;
    eb = 0;
    en = 1;
    regs;
    prep(15, 0);
    rst(1, 2'h1);
    waitIdle;
    ea = 1;
    eb = 1;
    es = 2;
    regs;
    chk(cpuRelease, 1);
    $display("test startup done");
    finish_test;
  end
endmodule : testbench
